// ==== hw/rtc_cal.v ====
// Functional notes
// R1 - timer select reads enable on D3, zeros on D2/D1, output flag on D0
// R2 - timer enable 0 keeps timer output released
// R3 - restart-to-expiry time 562ms at code 000, halving per code step
// R4 - without restart, output repeats every 625ms at code 000, halving per step
// R5 - host restart reloads timeout; expiry drives timer output low
// R6 - chip-enable low stops timer and releases pin; high restarts it
// R7 - oscillator stop clears timer enable and releases pin
// R8 - restart while output is low releases output at once
// R9 - seconds, minutes, hours as BCD digits at 0h..5h, unused bits zero
// R10 - second-carry enable 0 blocks prescaler carry into seconds
// R11 - seconds and minutes count 00..59 and carry on wrap
// R12 - hours carry into day and weekday at 11pm->12am or 23->00
// R13 - 12-hour tens 0/1 am, 2/3 pm; 12 midnight, 32 noon
// R14 - hour format bit 0 selects 12-hour, 1 selects 24-hour
// R15 - weekday at 6h counts 000..110 then wraps on day carry
// R16 - host never writes weekday 111
// R17 - day, month, year BCD digits at 7h..Ch, unused bits zero
// R18 - day ends at 31 or 30 by month, then wraps to 1 with carry
// R19 - february ends at 29 in leap years, 28 otherwise
// R20 - month counts 1..12 and carries into year on wrap
// R21 - year counts 00..99; multiples of four are leap when enabled
// R22 - year digit write clears leap disable; disabled means february ends at 28
// R23 - host never loads non-existent time or date values
// R24 - chip-enable high: read needs read and select low; write needs write and select
// R25 - chip-enable low disables bus pins and ignores strobes
// R26 - timer output flag reads 1 while timer output is driven low
// R27 - counters and timer derive from one 32.768 khz divider chain; the timer counts osc_tick in its own tmr_cnt, not the prescaler
`include "rtc_consts.vh"

module rtc_cal #(
    parameter [14:0] FREE_TICKS = `RTC_TMR_FREE_TICKS,
    parameter [14:0] LOW_TICKS = `RTC_TMR_LOW_TICKS
) (
    // clock and reset
    input wire mclk,
    input wire rst_b,
    input wire clk_en,
    // oscillator tick, one mclk pulse per 32.768 khz period
    input wire osc_tick,
    // host bus
    input wire ce,
    input wire cs_n,
    input wire rd_n,
    input wire wr_n,
    input wire setup_page,
    input wire [3:0] addr,
    input wire [3:0] data_in,
    output reg [3:0] data_out,
    output reg data_oe,
    // loose control bits
    input wire second_carry_enable,
    input wire timer_restart_bit,
    input wire osc_stopped_flag,
    input wire leap_disable_set,
    output reg leap_disable_bit,
    // open-drain timer pin
    output reg timer_output_n,
    output reg timer_output_n_oe
);

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // two-digit bcd increment, no wrap
    // callers pick the wrap point, so one adder serves every digit pair except the hours in 12-hour mode
    function [7:0] rtc_bcd_inc;
        input [7:0] v;
        begin
            if (v[3:0] == 4'h9) begin
                rtc_bcd_inc = {v[7:4] + 4'h1, 4'h0};
            end else begin
                rtc_bcd_inc = {v[7:4], v[3:0] + 4'h1};
            end
        end
    endfunction

    // last day of the month in bcd
    // a month outside 1..12 falls to the 31-day default
    function [7:0] rtc_day_max;
        input [7:0] mon;
        input lp;
        begin
            case (mon)
                8'h02: rtc_day_max = lp ? 8'h29 : 8'h28; // R19
                8'h04, 8'h06, 8'h09, 8'h11: rtc_day_max = 8'h30; // R18
                default: rtc_day_max = 8'h31; // R18
            endcase
        end
    endfunction

    // next hour code, top bit is the day carry
    // 12-hour codes run 12, 01..11, 32, 21..31: tens bit 1 is the pm flag
    function [8:0] rtc_hour_next;
        input [7:0] h;
        input fmt24;
        begin
            if (fmt24) begin
                if (h == 8'h23) begin
                    rtc_hour_next = {1'b1, 8'h00}; // R12
                end else begin
                    rtc_hour_next = {1'b0, rtc_bcd_inc(h)};
                end
            end else if (h[4] && h[3:0] == 4'h1) begin
                // 11 am goes to noon 32, 11 pm to midnight 12
                rtc_hour_next = h[5] ? {1'b1, 8'h12} : {1'b0, 8'h32}; // R12 R13
            end else if (h[4] && h[3:0] == 4'h2) begin
                rtc_hour_next = {1'b0, 2'b00, h[5], 1'b0, 4'h1}; // R13
            end else if (h[3:0] == 4'h9) begin
                rtc_hour_next = {1'b0, 2'b00, h[5], 1'b1, 4'h0}; // R13
            end else begin
                rtc_hour_next = {1'b0, h[7:4], h[3:0] + 4'h1};
            end
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    // digits stay packed bcd pairs, so carries and reads need no conversion
    reg [14:0] pre;
    reg [7:0] sec;
    reg [7:0] min;
    reg [7:0] hour;
    reg [2:0] wday;
    reg [7:0] day;
    reg [7:0] mon;
    reg [7:0] year;
    reg hour_24;
    reg tmr_en;
    reg [2:0] tmr_sel;
    reg [14:0] tmr_cnt;
    reg wr_act_q;
    reg [3:0] wa;
    reg [3:0] wd;
    reg wpage;

    // bus qualifiers, all gated by chip enable
    // a write is committed when its strobe ends, so data may still settle while
    // the strobe is low; the last value sampled before the end wins
    wire rd_act = ce & ~cs_n & ~rd_n; // R24 R25
    wire wr_act = ce & ~cs_n & ~wr_n; // R24 R25
    wire wr_go = wr_act_q & ~wr_act & ce; // R25
    wire wr_cnt = wr_go & ~wpage;
    wire wr_setup = wr_go & wpage;

    // calendar second tick from the prescaler; the timer divides oscillator ticks in its own counter
    // bcd leap test: odd tens need units 2 or 6, even tens units 0, 4 or 8
    // shifting by the code halves period and low span per step
    wire sec_tick = osc_tick & (pre == `RTC_PRE_LAST) & second_carry_enable; // R10 R27
    wire [1:0] leap_sum = year[1:0] + {year[4], 1'b0};
    wire is_leap = ~leap_disable_bit & (leap_sum == 2'b00); // R21 R22
    wire [8:0] hour_nx = rtc_hour_next(hour, hour_24);
    wire [14:0] tmr_per = FREE_TICKS >> tmr_sel; // R4
    wire [14:0] tmr_low = LOW_TICKS >> tmr_sel; // R3

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    // runs on regardless of the carry enable, so a stopped clock resumes in phase
    // limitation: the first second after reset lasts a full 32768 ticks
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pre <= 15'h0000;
        end else if (clk_en && osc_tick) begin
            pre <= pre + 15'h0001; // R27
        end
    end

    // ----------------------------------------
    // host write capture
    // ----------------------------------------
    // address and data are taken while the strobe is active and committed at its end
    // a strobe that ends while chip enable is low is dropped, as the pins are off
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_act_q <= 1'b0;
            wa <= 4'h0;
            wd <= 4'h0;
            wpage <= 1'b0;
        end else if (clk_en) begin
            wr_act_q <= wr_act;
            if (wr_act) begin
                wa <= addr;
                wd <= data_in;
                wpage <= setup_page;
            end
        end
    end

    // ----------------------------------------
    // time and calendar counters
    // ----------------------------------------
    // a host write lands after the count, so the written digit wins that cycle
    // the 1 hz carry ripples through every digit in one cycle, so a read never
    // sees a half-carried time; a carry out of a non-existent value is not guarded
    // weekday steps 110 to 000; a loaded 111 also steps to 000
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sec <= 8'h00;
            min <= 8'h00;
            hour <= `RTC_RST_HOUR;
            wday <= 3'h0;
            day <= `RTC_RST_DATE;
            mon <= `RTC_RST_DATE;
            year <= 8'h00;
        end else if (clk_en) begin
            if (sec_tick) begin
                if (sec == 8'h59) begin
                    sec <= 8'h00; // R11
                    if (min == 8'h59) begin
                        min <= 8'h00; // R11
                        hour <= hour_nx[7:0];
                        if (hour_nx[8]) begin
                            wday <= (wday == 3'h6) ? 3'h0 : wday + 3'h1; // R15
                            if (day == rtc_day_max(mon, is_leap)) begin
                                day <= 8'h01; // R18 R19
                                if (mon == 8'h12) begin
                                    mon <= 8'h01; // R20
                                    year <= (year == 8'h99) ? 8'h00 : rtc_bcd_inc(year); // R21
                                end else begin
                                    mon <= rtc_bcd_inc(mon); // R20
                                end
                            end else begin
                                day <= rtc_bcd_inc(day);
                            end
                        end
                    end else begin
                        min <= rtc_bcd_inc(min); // R11
                    end
                end else begin
                    sec <= rtc_bcd_inc(sec); // R11
                end
            end
            // unused high bits are dropped so they always read as zero
            if (wr_cnt) begin
                case (wa)
                    `RTC_A_SEC_U: sec[3:0] <= wd; // R9
                    `RTC_A_SEC_T: sec[7:4] <= {1'b0, wd[2:0]}; // R9
                    `RTC_A_MIN_U: min[3:0] <= wd; // R9
                    `RTC_A_MIN_T: min[7:4] <= {1'b0, wd[2:0]}; // R9
                    `RTC_A_HOUR_U: hour[3:0] <= wd; // R9
                    `RTC_A_HOUR_T: hour[7:4] <= {2'b00, wd[1:0]}; // R9 R13
                    `RTC_A_WDAY: wday <= wd[2:0]; // R15
                    `RTC_A_DAY_U: day[3:0] <= wd; // R17
                    `RTC_A_DAY_T: day[7:4] <= {2'b00, wd[1:0]}; // R17
                    `RTC_A_MON_U: mon[3:0] <= wd; // R17
                    `RTC_A_MON_T: mon[7:4] <= {3'b000, wd[0]}; // R17
                    `RTC_A_YEAR_U: year[3:0] <= wd; // R17
                    `RTC_A_YEAR_T: year[7:4] <= wd; // R17
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // setup bits: hour format, leap disable, timer select
    // ----------------------------------------
    // the hour format converts nothing already loaded: set it before the hour digits
    // year writes are seen at the commit edge, the edge on which the digit lands
    wire year_wr = wr_cnt & (wa == `RTC_A_YEAR_U || wa == `RTC_A_YEAR_T);
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hour_24 <= 1'b0;
            leap_disable_bit <= 1'b0;
            tmr_en <= 1'b0;
            tmr_sel <= 3'h0;
        end else if (clk_en) begin
            if (wr_setup && wa == `RTC_A_HOUR_FMT) begin
                hour_24 <= wd[`RTC_HOUR_FMT_BIT]; // R14
            end
            // a set in the same cycle as a year write wins
            if (leap_disable_set) begin
                leap_disable_bit <= 1'b1;
            end else if (year_wr) begin
                leap_disable_bit <= 1'b0; // R22
            end
            // a new code acts at once; a count already past the new period expires
            // on the next oscillator tick
            if (wr_setup && wa == `RTC_A_TMR_SEL) begin
                tmr_en <= wd[`RTC_TMR_EN_BIT];
                tmr_sel <= wd[2:0];
            end
            // oscillator stop overrides any host write of the enable
            if (osc_stopped_flag) begin
                tmr_en <= 1'b0; // R7
            end
        end
    end

    // ----------------------------------------
    // interval timer
    // ----------------------------------------
    // counts oscillator ticks over one free-running period; the pin is low for the
    // first tmr_low ticks after expiry, and a restart jumps to tmr_low so the next
    // expiry comes tmr_per - tmr_low ticks later
    // the pin value is tied low as an open-drain pin; only its enable moves
    // a restart outranks an expiry in the same cycle, so a host that keeps
    // restarting in time never sees the pin fall
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_cnt <= 15'h0000;
            timer_output_n_oe <= 1'b0;
            timer_output_n <= 1'b0;
        end else if (clk_en) begin
            timer_output_n <= 1'b0;
            if (!ce || !tmr_en || osc_stopped_flag) begin
                // parked as after a restart, so chip enable rising restarts it
                tmr_cnt <= tmr_low; // R6
                timer_output_n_oe <= 1'b0; // R2 R6 R7
            end else if (timer_restart_bit) begin
                tmr_cnt <= tmr_low; // R3 R5
                timer_output_n_oe <= 1'b0; // R8
            end else if (osc_tick) begin
                if (tmr_cnt >= tmr_per - 15'h0001) begin
                    tmr_cnt <= 15'h0000;
                    timer_output_n_oe <= 1'b1; // R4 R5
                end else begin
                    tmr_cnt <= tmr_cnt + 15'h0001;
                    if (tmr_cnt == tmr_low - 15'h0001) begin
                        timer_output_n_oe <= 1'b0;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // unmapped offsets and the write-only hour format read as zero
    // timer select reads back only the enable and the live output flag
    reg [3:0] rd_mux;
    always @* begin
        rd_mux = 4'h0;
        if (setup_page) begin
            if (addr == `RTC_A_TMR_SEL) begin
                rd_mux = {tmr_en, 2'b00, timer_output_n_oe}; // R1 R26
            end
        end else begin
            case (addr)
                `RTC_A_SEC_U: rd_mux = sec[3:0];
                `RTC_A_SEC_T: rd_mux = sec[7:4];
                `RTC_A_MIN_U: rd_mux = min[3:0];
                `RTC_A_MIN_T: rd_mux = min[7:4];
                `RTC_A_HOUR_U: rd_mux = hour[3:0];
                `RTC_A_HOUR_T: rd_mux = hour[7:4];
                `RTC_A_WDAY: rd_mux = {1'b0, wday};
                `RTC_A_DAY_U: rd_mux = day[3:0];
                `RTC_A_DAY_T: rd_mux = day[7:4];
                `RTC_A_MON_U: rd_mux = mon[3:0];
                `RTC_A_MON_T: rd_mux = mon[7:4];
                `RTC_A_YEAR_U: rd_mux = year[3:0];
                `RTC_A_YEAR_T: rd_mux = year[7:4];
                default: rd_mux = 4'h0;
            endcase
        end
    end

    // data pins are driven one cycle after the read becomes active
    // the lag costs one cycle of access time but keeps every output on a flip-flop
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            data_out <= 4'h0;
            data_oe <= 1'b0;
        end else if (clk_en) begin
            data_oe <= rd_act; // R24 R25
            data_out <= rd_act ? rd_mux : 4'h0;
        end
    end

endmodule

// ==== hw/rtc_consts.vh ====
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH

// ----------------------------------------
// counter page register offsets
// ----------------------------------------
`define RTC_A_SEC_U 4'h0
`define RTC_A_SEC_T 4'h1
`define RTC_A_MIN_U 4'h2
`define RTC_A_MIN_T 4'h3
`define RTC_A_HOUR_U 4'h4
`define RTC_A_HOUR_T 4'h5
`define RTC_A_WDAY 4'h6
`define RTC_A_DAY_U 4'h7
`define RTC_A_DAY_T 4'h8
`define RTC_A_MON_U 4'h9
`define RTC_A_MON_T 4'ha
`define RTC_A_YEAR_U 4'hb
`define RTC_A_YEAR_T 4'hc

// ----------------------------------------
// setup page register offsets and fields
// ----------------------------------------
`define RTC_A_HOUR_FMT 4'ha
`define RTC_A_TMR_SEL 4'hc
`define RTC_TMR_EN_BIT 3
`define RTC_HOUR_FMT_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RTC_RST_HOUR 8'h12
`define RTC_RST_DATE 8'h01
`define RTC_RST_ZERO 4'h0

// ----------------------------------------
// timing, counted in 32.768 khz oscillator ticks
// ----------------------------------------
`define RTC_PRE_LAST 15'h7fff
// free-running period at code 000: 625 ms of oscillator ticks
`define RTC_TMR_FREE_TICKS 15'h5000
// output low span, a tenth of the period, so restart-to-expiry is 562.5 ms at code 000
`define RTC_TMR_LOW_TICKS 15'h0800

`endif

// ==== verification/rtc_cal_assertions.sv ====
module rtc_cal_assertions (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    // host bus
    input wire logic ce,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic [3:0] data_out,
    input wire logic data_oe,
    // loose bits and timer pin
    input wire logic timer_restart_bit,
    input wire logic osc_stopped_flag,
    input wire logic leap_disable_set,
    input wire logic leap_disable_bit,
    input wire logic timer_output_n,
    input wire logic timer_output_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // a read is live only with chip enable, select and strobe together
    wire rd_act = clk_en && ce && !cs_n && !rd_n;
    sequence s_read;
        rd_act;
    endsequence
    sequence s_idle;
        clk_en && !rd_act;
    endsequence
    a_pin_value_low: assert property (timer_output_n_oe |-> timer_output_n == 1'h0)
        else $error("timer pin driven high");
    a_ce_low_release: assert property (clk_en && !ce |=> !timer_output_n_oe)
        else $error("timer pin held with chip disabled");
    a_osc_stop_release: assert property (clk_en && osc_stopped_flag |=> !timer_output_n_oe)
        else $error("timer pin held after oscillator stop");
    a_restart_release: assert property (clk_en && timer_restart_bit |=> !timer_output_n_oe)
        else $error("timer pin held after restart");
    a_read_drives_bus: assert property (s_read |=> data_oe)
        else $error("read not answered");
    a_idle_bus_off: assert property (s_idle |=> !data_oe)
        else $error("bus driven without read");
    a_idle_data_zero: assert property (!data_oe |-> data_out == 4'h0)
        else $error("read data left on idle bus");
    a_leap_set_sticks: assert property (clk_en && leap_disable_set |=> leap_disable_bit)
        else $error("leap disable not set");
endmodule

// ==== verification/rtc_host_pins.sv ====
module rtc_host_pins (
    // clock
    input wire logic mclk,
    // device side
    input wire logic [3:0] data_out,
    input wire logic data_oe,
    input wire logic timer_output_n,
    input wire logic timer_output_n_oe,
    // wires as the host sees them
    output wire logic [3:0] data_bus,
    output wire logic timer_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] last_bus = 4'h0;
    // open-drain timer line with a board pull-up
    assign timer_pin = timer_output_n_oe ? timer_output_n : 1'h1;
    // released lines show the inverse of the last value, so a stale read never passes
    always @(posedge mclk) begin
        if (data_oe) begin
            last_bus <= data_out;
        end
    end
    assign data_bus = data_oe ? data_out : ~last_bus;
endmodule

// ==== verification/test_rtc_cal.sv ====
module test_rtc_cal;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0;
    logic rst_b = 1'h0;
    logic ce = 1'h1, cs_n = 1'h1, rd_n = 1'h1, wr_n = 1'h1, setup_page = 1'h0;
    logic [3:0] addr = 4'h0, data_in = 4'h0;
    logic second_carry_enable = 1'h0, timer_restart_bit = 1'h0;
    logic osc_stopped_flag = 1'h0, leap_disable_set = 1'h0, clk_en = 1'h1;
    wire [3:0] data_out, data_bus;
    wire data_oe, leap_disable_bit, timer_output_n, timer_output_n_oe, timer_pin;
    int bad_count = 0, n_checks = 0, cyc = 0;
    logic [15:0] span, lo;
    // ------------------------------------
    // clock, cycle count, design and host wires
    // ------------------------------------
    initial forever #2.5 mclk = ~mclk;
    always @(posedge mclk) if (rst_b) cyc <= cyc + 1;
    // osc tick every cycle so a second lasts 32768 cycles
    rtc_cal #(.FREE_TICKS(15'h00a0), .LOW_TICKS(15'h0010)) dut (
        .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .osc_tick(1'h1), .ce(ce), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .setup_page(setup_page), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .second_carry_enable(second_carry_enable),
        .timer_restart_bit(timer_restart_bit), .osc_stopped_flag(osc_stopped_flag),
        .leap_disable_set(leap_disable_set), .leap_disable_bit(leap_disable_bit),
        .timer_output_n(timer_output_n), .timer_output_n_oe(timer_output_n_oe));
    rtc_host_pins host (.mclk(mclk), .data_out(data_out), .data_oe(data_oe),
        .timer_output_n(timer_output_n), .timer_output_n_oe(timer_output_n_oe),
        .data_bus(data_bus), .timer_pin(timer_pin));
    // ------------------------------------
    // bus cycles and compares
    // ------------------------------------
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check_span(input logic [15:0] g, input logic [15:0] l, input logic [15:0] h);
        n_checks++;
        if (^g === 1'hx || g < l || g > h) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h..%h", $time, g, l, h);
        end
    endtask
    // strobe low one edge, high again; the digit is updated on the first of the two edges that follow
    task automatic bus_write(input logic pg, input logic [3:0] a, input logic [3:0] d);
        @(posedge mclk);
        {setup_page, addr, data_in, cs_n, wr_n} <= {pg, a, d, 2'h0};
        @(posedge mclk);
        {cs_n, wr_n} <= 2'h3;
        repeat (2) @(posedge mclk);
    endtask
    task automatic expect_reg(input logic pg, input logic [3:0] a, input logic [3:0] e);
        logic [3:0] g;
        @(posedge mclk);
        {setup_page, addr, cs_n, rd_n} <= {pg, a, 2'h0};
        repeat (2) @(posedge mclk);
        #1 g = data_bus;
        @(posedge mclk);
        {cs_n, rd_n} <= 2'h3;
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic pulse_restart;
        @(posedge mclk);
        timer_restart_bit <= 1'h1;
        @(posedge mclk);
        timer_restart_bit <= 1'h0;
    endtask
    // counts edges until the pin reaches lvl; a hang ends the run
    task automatic wait_pin(input logic lvl, output logic [15:0] n);
        #1 n = 0;
        while (timer_pin !== lvl) begin
            @(posedge mclk);
            #1 n++;
            if (n > 1000) begin
                bad_count++;
                complete_run();
            end
        end
    endtask
    task automatic wait_until(input int c);
        while (cyc < c) @(posedge mclk);
    endtask
    // digits packed from seconds units (low nibble) up to year tens
    task automatic load_cal(input logic [51:0] v);
        for (int i = 0; i < 13; i++) bus_write(1'h0, i[3:0], v[4*i+:4]);
    endtask
    task automatic check_cal(input logic [51:0] e);
        for (int i = 0; i < 13; i++) expect_reg(1'h0, i[3:0], e[4*i+:4]);
    endtask
    // ------------------------------------
    // main sequence
    // ------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'h1;
        bus_write(1'h1, 4'hc, 4'h0);
        pulse_restart();
        span = 0;
        repeat (300) begin
            @(posedge mclk);
            #1 span += (timer_pin !== 1'h1);
        end
        check_span(span, 0, 0);
        bus_write(1'h1, 4'hc, 4'h8);
        pulse_restart();
        wait_pin(1'h0, span);
        check_span(span, 141, 147);
        wait_pin(1'h1, lo);
        wait_pin(1'h0, span);
        check_span(lo, 13, 19);
        check_span(lo + span, 157, 163);
        expect_reg(1'h1, 4'hc, 4'h9);
        pulse_restart();
        wait_pin(1'h1, span);
        check_span(span, 0, 0);
        expect_reg(1'h1, 4'hc, 4'h8);
        // clock enable low freezes the low span: one tick before, fifteen after
        wait_pin(1'h0, span);
        @(posedge mclk);
        clk_en <= 1'h0;
        repeat (40) @(posedge mclk);
        clk_en <= 1'h1;
        wait_pin(1'h1, lo);
        check_span(lo, 14, 16);
        bus_write(1'h1, 4'hc, 4'h9);
        pulse_restart();
        wait_pin(1'h0, span);
        check_span(span, 69, 75);
        @(posedge mclk);
        ce <= 1'h0;
        bus_write(1'h1, 4'hc, 4'h0);
        check_span(timer_pin, 1, 1);
        @(posedge mclk);
        ce <= 1'h1;
        wait_pin(1'h0, span);
        check_span(span, 69, 76);
        expect_reg(1'h1, 4'hc, 4'h9);
        @(posedge mclk);
        osc_stopped_flag <= 1'h1;
        @(posedge mclk);
        osc_stopped_flag <= 1'h0;
        expect_reg(1'h1, 4'hc, 4'h0);
        check_span(timer_pin, 1, 1);
        bus_write(1'h0, 4'h6, 4'he);
        expect_reg(1'h0, 4'h6, 4'h6);
        expect_reg(1'h1, 4'h0, 4'h0);
        bus_write(1'h1, 4'ha, 4'h1);
        load_cal(52'h0302286235959);
        wait_until(33000);
        expect_reg(1'h0, 4'h0, 4'h9);
        @(posedge mclk);
        second_carry_enable <= 1'h1;
        wait_until(65700);
        check_cal(52'h0303010000000);
        @(posedge mclk);
        leap_disable_set <= 1'h1;
        @(posedge mclk);
        leap_disable_set <= 1'h0;
        #1 check_span(leap_disable_bit, 1, 1);
        bus_write(1'h1, 4'ha, 4'h0);
        load_cal(52'h0402280315959);
        check_span(leap_disable_bit, 0, 0);
        wait_until(98500);
        check_cal(52'h0402291120000);
        complete_run();
    end
endmodule

bind rtc_cal rtc_cal_assertions u_chk (
    .mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .ce(ce), .cs_n(cs_n), .rd_n(rd_n),
    .data_out(data_out), .data_oe(data_oe), .timer_restart_bit(timer_restart_bit),
    .osc_stopped_flag(osc_stopped_flag), .leap_disable_set(leap_disable_set),
    .leap_disable_bit(leap_disable_bit), .timer_output_n(timer_output_n),
    .timer_output_n_oe(timer_output_n_oe));
